// *** design/mrt_cfg.svh ***
// Offsets, field positions, defaults and timing of the monitor block
`ifndef MRT_CFG_SVH
`define MRT_CFG_SVH
`define MRT_CLK_NS 20
`define MRT_RR_NS 1000000
`define MRT_ADDR_BASE 7'h40
`define MRT_CMD_OT_FAULT 8'h4F
`define MRT_CMD_OT_WARN 8'h51
`define MRT_CMD_VIN_OV 8'h57
`define MRT_CMD_VIN_UV 8'h58
`define MRT_CMD_STAT_TEMP 8'h7D
`define MRT_CMD_VIN 8'h88
`define MRT_CMD_TEMP 8'h8D
`define MRT_CMD_VAUX 8'hD0
`define MRT_CMD_IIN 8'hD1
`define MRT_CMD_PIN 8'hD2
`define MRT_CMD_IIN_OC 8'hD3
`define MRT_CMD_PIN_OP 8'hD4
`define MRT_CMD_PIN_PEAK 8'hD5
`define MRT_CMD_CLR_PEAK 8'hD6
`define MRT_CMD_SETUP 8'hD9
`define MRT_CMD_VAUX_OV 8'hE0
`define MRT_CMD_AVG_BASE 8'hE1
`define MRT_DEF_OT_FAULT 16'h0960
`define MRT_DEF_OT_WARN 16'h07D0
`define MRT_DEF_HI_LIM 16'h0FFF
`define MRT_DEF_LO_LIM 16'h0000
`define MRT_DEF_SETUP 8'h00
`define MRT_SETUP_GAIN 2
`define MRT_SETUP_AVG_LSB 4
`define MRT_SETUP_SWRST 7
`define MRT_STAT_OT_FAULT 7
`define MRT_STAT_OT_WARN 6
`define MRT_FS_LO_MV 30
`define MRT_FS_HI_MV 60
`endif

// *** design/mrt_pkg.sv ***
// Types shared by the monitor block
package mrt_pkg;
  typedef logic [11:0] mrt_code_t;
  typedef logic [15:0] mrt_word_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_VIN = 3'h1,
    SEQ_IIN = 3'h2,
    SEQ_VAUX = 3'h3,
    SEQ_TLO = 3'h4,
    SEQ_THI = 3'h5
  } mrt_seq_e;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_ACK = 3'h2,
    BUS_WR = 3'h3,
    BUS_RD = 3'h4,
    BUS_RACK = 3'h5
  } mrt_bus_e;
endpackage

// *** design/mrt_sync2.sv ***
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module mrt_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] dataIn,
  output logic [W-1:0] dataSyncFf
);
  logic [W-1:0] stage1Ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1Ff <= RST_VAL;
      dataSyncFf <= RST_VAL;
    end else begin
      stage1Ff <= dataIn;
      dataSyncFf <= stage1Ff;
    end
  end
endmodule

// *** design/mrt_smbus_slave.sv ***
// Byte-level serial management bus slave
`timescale 1ns/1ps
module mrt_smbus_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold,
  input wire logic sclSync,
  input wire logic sdaSync,
  input wire logic [6:0] devAddr,
  input wire logic addrValid,
  input wire mrt_pkg::mrt_word_t rdWord,
  output logic sdaOeFf,
  output logic rxValidFf,
  output logic rxFirstFf,
  output logic [7:0] rxDataFf
);
  import mrt_pkg::*;

  mrt_bus_e stateFf;
  logic sclPrevFf;
  logic sdaPrevFf;
  logic isReadFf;
  logic firstFf;
  logic nackFf;
  logic rdIdxFf;
  logic [3:0] cntFf;
  logic [7:0] shFf;
  logic [7:0] txFf;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [7:0] txByte;

  assign sclRise = sclSync & ~sclPrevFf;
  assign sclFall = ~sclSync & sclPrevFf;
  assign startCond = sclSync & sclPrevFf & sdaPrevFf & ~sdaSync;
  assign stopCond = sclSync & sclPrevFf & ~sdaPrevFf & sdaSync;
  // Low byte goes out first
  assign txByte = rdIdxFf ? rdWord[15:8] : rdWord[7:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclPrevFf <= 1'b1;
      sdaPrevFf <= 1'b1;
    end else begin
      sclPrevFf <= sclSync;
      sdaPrevFf <= sdaSync;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stateFf <= BUS_IDLE;
      sdaOeFf <= 1'b0;
      rxValidFf <= 1'b0;
      rxFirstFf <= 1'b0;
      rxDataFf <= 8'h00;
      isReadFf <= 1'b0;
      firstFf <= 1'b0;
      nackFf <= 1'b0;
      rdIdxFf <= 1'b0;
      cntFf <= 4'h0;
      shFf <= 8'h00;
      txFf <= 8'h00;
    end else if (hold) begin
      stateFf <= BUS_IDLE;
      sdaOeFf <= 1'b0;
      rxValidFf <= 1'b0;
    end else begin
      rxValidFf <= 1'b0;
      if (startCond) begin
        stateFf <= BUS_ADDR;
        cntFf <= 4'h0;
        sdaOeFf <= 1'b0;
      end else if (stopCond) begin
        stateFf <= BUS_IDLE;
        sdaOeFf <= 1'b0;
      end else if (sclRise) begin
        if ((stateFf == BUS_ADDR || stateFf == BUS_WR) && cntFf != 4'h8) begin
          shFf <= {shFf[6:0], sdaSync};
          cntFf <= cntFf + 4'h1;
        end else if (stateFf == BUS_RD) begin
          cntFf <= cntFf + 4'h1;
        end else if (stateFf == BUS_RACK) begin
          nackFf <= sdaSync;
        end
      end else if (sclFall) begin
        unique case (stateFf)
          BUS_IDLE: stateFf <= BUS_IDLE;
          BUS_ADDR: if (cntFf == 4'h8) begin
            if (addrValid && shFf[7:1] == devAddr) begin
              sdaOeFf <= 1'b1;
              isReadFf <= shFf[0];
              firstFf <= ~shFf[0];
              rdIdxFf <= 1'b0;
              stateFf <= BUS_ACK;
            end else begin
              stateFf <= BUS_IDLE;
            end
          end
          BUS_WR: if (cntFf == 4'h8) begin
            rxDataFf <= shFf;
            rxFirstFf <= firstFf;
            rxValidFf <= 1'b1;
            firstFf <= 1'b0;
            sdaOeFf <= 1'b1;
            stateFf <= BUS_ACK;
          end
          BUS_ACK: begin
            cntFf <= 4'h0;
            if (isReadFf) begin
              txFf <= txByte;
              sdaOeFf <= ~txByte[7];
              stateFf <= BUS_RD;
            end else begin
              sdaOeFf <= 1'b0;
              stateFf <= BUS_WR;
            end
          end
          BUS_RD: if (cntFf == 4'h8) begin
            sdaOeFf <= 1'b0;
            rdIdxFf <= ~rdIdxFf;
            stateFf <= BUS_RACK;
          end else begin
            sdaOeFf <= ~txFf[3'h7 - cntFf[2:0]];
          end
          BUS_RACK: if (nackFf) begin
            stateFf <= BUS_IDLE;
          end else begin
            txFf <= txByte;
            sdaOeFf <= ~txByte[7];
            cntFf <= 4'h0;
            stateFf <= BUS_RD;
          end
          default: stateFf <= BUS_IDLE;
        endcase
      end
    end
  end
endmodule

// *** design/mrt_monitor.sv ***
// Monitor reset sequencing, telemetry sequencer and alarm logic
//
// What this block does
// - Enable low: low-current state, bus commands addressed to us ignored.
// - Enable low is a full reset; rising enable restores every default.
// - Enable reads as enabled when the pin is left floating.
// - Held in reset until both rails pass power-on; rail loss clears all.
// - Address from three three-level straps, latched after enable and POR.
// - Software reset bit in the setup register resets all volatile state except the latched address.
// - Software reset keeps the latched address; only hardware resets resample.
// - Diode excitation pulses high once a millisecond; temperature from step.
// - Temperature read command returns the latest temperature result.
// - Alert pulled low while temperature exceeds warn limit (default 07D0).
// - Fault status set while temperature exceeds fault limit (default 0960).
// - Warn and fault limits each writable through their own commands.
// - Warn limits for voltage, aux, current, power, temperature raise alert.
// - Track peak input power; programmable averages of five channels.
// - Range bit selects 30 mV full scale when clear, 60 mV when set.
// - Every telemetry channel refreshed once per millisecond round.
`timescale 1ns/1ps
`include "mrt_cfg.svh"
module mrt_monitor #(
  parameter int RR_CYC = `MRT_RR_NS / `MRT_CLK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enablePin,
  input wire logic vddPorOk,
  input wire logic vrefPorOk,
  input wire logic [1:0] addrStrapBit0,
  input wire logic [1:0] addrStrapBit1,
  input wire logic [1:0] addrStrapBit2,
  input wire logic sclPin,
  input wire logic sdaPinIn,
  output logic sdaPinOut,
  output logic sdaPinOe,
  output logic alertLineOut,
  output logic alertLineOe,
  output logic adcStart,
  output logic [2:0] adcChan,
  input wire logic adcDone,
  input wire mrt_pkg::mrt_code_t adcData,
  output logic diodeHighCurrent,
  output logic currentRangeHigh,
  output logic lowPower,
  output logic otFault
);
  import mrt_pkg::*;

  localparam int TW = $clog2(RR_CYC + 1);
  localparam int NLIM = 7;
  localparam int NAVG = 5;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Straps read 0 ground, 1 open, 2 supply; code 3 is taken as open
  function automatic logic [6:0] strapVal(input logic [1:0] s);
    strapVal = (s == 2'h3) ? 7'h01 : {5'h00, s};
  endfunction

  function automatic logic [7:0] limCode(input int i);
    case (i)
      0: limCode = `MRT_CMD_OT_FAULT;
      1: limCode = `MRT_CMD_OT_WARN;
      2: limCode = `MRT_CMD_VIN_OV;
      3: limCode = `MRT_CMD_VIN_UV;
      4: limCode = `MRT_CMD_IIN_OC;
      5: limCode = `MRT_CMD_PIN_OP;
      default: limCode = `MRT_CMD_VAUX_OV;
    endcase
  endfunction

  function automatic mrt_word_t limDefault(input int i);
    case (i)
      0: limDefault = `MRT_DEF_OT_FAULT;
      1: limDefault = `MRT_DEF_OT_WARN;
      3: limDefault = `MRT_DEF_LO_LIM;
      default: limDefault = `MRT_DEF_HI_LIM;
    endcase
  endfunction

  // Averaging trades response time for noise; k of zero passes through
  function automatic mrt_code_t avgStep(
    input mrt_code_t a,
    input mrt_code_t x,
    input logic [2:0] k
  );
    logic signed [12:0] d;
    d = $signed({1'b0, x}) - $signed({1'b0, a});
    d = d >>> k;
    avgStep = mrt_code_t'($signed({1'b0, a}) + d);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] ctlSync;
  logic [1:0] busSync;

  // Enable resets to one so a floating pin keeps the part running
  mrt_sync2 #(.W(9), .RST_VAL(9'h100)) uCtlSync (
    .clock(clock),
    .rst(rst),
    .dataIn({enablePin, vddPorOk, vrefPorOk, addrStrapBit2,
             addrStrapBit1, addrStrapBit0}),
    .dataSyncFf(ctlSync)
  );

  mrt_sync2 #(.W(2), .RST_VAL(2'h3)) uBusSync (
    .clock(clock),
    .rst(rst),
    .dataIn({sclPin, sdaPinIn}),
    .dataSyncFf(busSync)
  );

  // ----------------------------------------------------------------
  // Reset sequencing and address capture
  // ----------------------------------------------------------------
  logic hwHold;
  logic funcClr;
  logic swRstFf;
  logic addrValidFf;
  logic [6:0] devAddrFf;

  assign hwHold = ~ctlSync[8] | ~ctlSync[7] | ~ctlSync[6];
  assign funcClr = hwHold | swRstFf;
  assign lowPower = hwHold;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addrValidFf <= 1'b0;
      devAddrFf <= 7'h00;
    end else if (hwHold) begin
      addrValidFf <= 1'b0;
    end else if (!addrValidFf) begin
      addrValidFf <= 1'b1;
      devAddrFf <= `MRT_ADDR_BASE + strapVal(ctlSync[1:0])
        + 7'(3 * strapVal(ctlSync[3:2]))
        + 7'(9 * strapVal(ctlSync[5:4]));
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and command staging
  // ----------------------------------------------------------------
  logic sdaOe;
  logic rxValid;
  logic rxFirst;
  logic [7:0] rxData;
  mrt_word_t rdWord;
  logic [7:0] cmdFf;
  logic [7:0] wrLoFf;
  logic wrIdxFf;
  logic wrCommit;
  logic setupCommit;
  mrt_word_t wrWord;

  mrt_smbus_slave uSlave (
    .clock(clock),
    .rst(rst),
    .hold(funcClr),
    .sclSync(busSync[1]),
    .sdaSync(busSync[0]),
    .devAddr(devAddrFf),
    .addrValid(addrValidFf),
    .rdWord(rdWord),
    .sdaOeFf(sdaOe),
    .rxValidFf(rxValid),
    .rxFirstFf(rxFirst),
    .rxDataFf(rxData)
  );

  assign sdaPinOut = 1'b0;
  assign sdaPinOe = sdaOe;
  assign wrWord = {rxData, wrLoFf};
  assign wrCommit = rxValid & ~rxFirst & wrIdxFf;
  assign setupCommit = rxValid & ~rxFirst & ~wrIdxFf
    & (cmdFf == `MRT_CMD_SETUP);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmdFf <= 8'h00;
      wrLoFf <= 8'h00;
      wrIdxFf <= 1'b0;
    end else if (funcClr) begin
      cmdFf <= 8'h00;
      wrIdxFf <= 1'b0;
    end else if (rxValid && rxFirst) begin
      cmdFf <= rxData;
      wrIdxFf <= 1'b0;
    end else if (rxValid) begin
      wrLoFf <= rxData;
      wrIdxFf <= ~wrIdxFf;
    end
  end

  // ----------------------------------------------------------------
  // Setup register and software reset
  // ----------------------------------------------------------------
  logic [7:0] setupFf;

  // Reset bit is a one-shot and never reads back as set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swRstFf <= 1'b0;
    end else begin
      swRstFf <= setupCommit & rxData[`MRT_SETUP_SWRST];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      setupFf <= `MRT_DEF_SETUP;
    end else if (funcClr) begin
      setupFf <= `MRT_DEF_SETUP;
    end else if (setupCommit) begin
      setupFf <= rxData & ~(8'h01 << `MRT_SETUP_SWRST);
    end
  end

  assign currentRangeHigh = setupFf[`MRT_SETUP_GAIN];

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  mrt_word_t limFf [NLIM];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NLIM; i++) begin
        limFf[i] <= limDefault(i);
      end
    end else if (funcClr) begin
      for (int i = 0; i < NLIM; i++) begin
        limFf[i] <= limDefault(i);
      end
    end else if (wrCommit) begin
      for (int i = 0; i < NLIM; i++) begin
        if (cmdFf == limCode(i)) begin
          limFf[i] <= wrWord;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  mrt_seq_e seqFf;
  logic [TW-1:0] tickCntFf;
  logic adcStartFf;
  logic roundDoneFf;
  logic sampleValidFf;
  mrt_code_t vinFf;
  mrt_code_t iinFf;
  mrt_code_t vauxFf;
  mrt_code_t pinFf;
  mrt_code_t tLoFf;
  mrt_code_t tempFf;
  mrt_code_t peakFf;
  logic [23:0] prod;

  assign prod = vinFf * adcData;
  assign adcStart = adcStartFf;
  assign adcChan = 3'(seqFf);
  assign diodeHighCurrent = (seqFf == SEQ_THI);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickCntFf <= '0;
    end else if (funcClr || tickCntFf == TW'(RR_CYC - 1)) begin
      tickCntFf <= '0;
    end else begin
      tickCntFf <= tickCntFf + TW'(1);
    end
  end

  // A round that overruns the tick is not restarted; the tick is lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seqFf <= SEQ_IDLE;
      adcStartFf <= 1'b0;
      roundDoneFf <= 1'b0;
      vinFf <= '0;
      iinFf <= '0;
      vauxFf <= '0;
      pinFf <= '0;
      tLoFf <= '0;
      tempFf <= '0;
    end else if (funcClr) begin
      seqFf <= SEQ_IDLE;
      adcStartFf <= 1'b0;
      roundDoneFf <= 1'b0;
      vinFf <= '0;
      iinFf <= '0;
      vauxFf <= '0;
      pinFf <= '0;
      tLoFf <= '0;
      tempFf <= '0;
    end else begin
      adcStartFf <= 1'b0;
      roundDoneFf <= 1'b0;
      unique case (seqFf)
        SEQ_IDLE: if (tickCntFf == TW'(RR_CYC - 1)) begin
          seqFf <= SEQ_VIN;
          adcStartFf <= 1'b1;
        end
        SEQ_VIN: if (adcDone) begin
          vinFf <= adcData;
          seqFf <= SEQ_IIN;
          adcStartFf <= 1'b1;
        end
        SEQ_IIN: if (adcDone) begin
          iinFf <= adcData;
          pinFf <= prod[23:12];
          seqFf <= SEQ_VAUX;
          adcStartFf <= 1'b1;
        end
        SEQ_VAUX: if (adcDone) begin
          vauxFf <= adcData;
          seqFf <= SEQ_TLO;
          adcStartFf <= 1'b1;
        end
        SEQ_TLO: if (adcDone) begin
          tLoFf <= adcData;
          seqFf <= SEQ_THI;
          adcStartFf <= 1'b1;
        end
        SEQ_THI: if (adcDone) begin
          tempFf <= adcData - tLoFf;
          seqFf <= SEQ_IDLE;
          roundDoneFf <= 1'b1;
        end
        default: seqFf <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peak power and averaging
  // ----------------------------------------------------------------
  mrt_code_t avgFf [NAVG];
  mrt_code_t chanVal [NAVG];
  logic clrPeak;

  assign chanVal[0] = vinFf;
  assign chanVal[1] = iinFf;
  assign chanVal[2] = pinFf;
  assign chanVal[3] = tempFf;
  assign chanVal[4] = vauxFf;
  assign clrPeak = rxValid & rxFirst & (rxData == `MRT_CMD_CLR_PEAK);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      peakFf <= '0;
    end else if (funcClr) begin
      peakFf <= '0;
    end else if (roundDoneFf && (clrPeak || pinFf > peakFf)) begin
      peakFf <= pinFf;
    end else if (clrPeak) begin
      peakFf <= '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NAVG; i++) begin
        avgFf[i] <= '0;
      end
    end else if (funcClr) begin
      for (int i = 0; i < NAVG; i++) begin
        avgFf[i] <= '0;
      end
    end else if (roundDoneFf) begin
      for (int i = 0; i < NAVG; i++) begin
        avgFf[i] <= avgStep(avgFf[i], chanVal[i],
          setupFf[`MRT_SETUP_AVG_LSB +: 3]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm comparison
  // ----------------------------------------------------------------
  logic warnTemp;
  logic warnAny;
  logic alertFf;
  logic otFaultFf;

  assign warnTemp = {4'h0, tempFf} > limFf[1];
  assign warnAny = warnTemp
    | ({4'h0, vinFf} > limFf[2])
    | ({4'h0, vinFf} < limFf[3])
    | ({4'h0, iinFf} > limFf[4])
    | ({4'h0, pinFf} > limFf[5])
    | ({4'h0, vauxFf} > limFf[6]);

  // Compare only after a full round so stale zeros raise nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sampleValidFf <= 1'b0;
      alertFf <= 1'b0;
      otFaultFf <= 1'b0;
    end else if (funcClr) begin
      sampleValidFf <= 1'b0;
      alertFf <= 1'b0;
      otFaultFf <= 1'b0;
    end else begin
      if (roundDoneFf) begin
        sampleValidFf <= 1'b1;
      end
      alertFf <= sampleValidFf & warnAny;
      otFaultFf <= sampleValidFf
        & ({4'h0, tempFf} > limFf[0]);
    end
  end

  assign alertLineOut = 1'b0;
  assign alertLineOe = alertFf;
  assign otFault = otFaultFf;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdWord = 16'h0000;
    case (cmdFf)
      `MRT_CMD_TEMP: rdWord = {4'h0, tempFf};
      `MRT_CMD_VIN: rdWord = {4'h0, vinFf};
      `MRT_CMD_IIN: rdWord = {4'h0, iinFf};
      `MRT_CMD_VAUX: rdWord = {4'h0, vauxFf};
      `MRT_CMD_PIN: rdWord = {4'h0, pinFf};
      `MRT_CMD_PIN_PEAK: rdWord = {4'h0, peakFf};
      `MRT_CMD_SETUP: rdWord = {8'h00, setupFf};
      `MRT_CMD_STAT_TEMP: begin
        rdWord[`MRT_STAT_OT_FAULT] = otFaultFf;
        rdWord[`MRT_STAT_OT_WARN] = sampleValidFf & warnTemp;
      end
      default: begin
        for (int i = 0; i < NLIM; i++) begin
          if (cmdFf == limCode(i)) begin
            rdWord = limFf[i];
          end
        end
        for (int i = 0; i < NAVG; i++) begin
          if (cmdFf == `MRT_CMD_AVG_BASE + 8'(i)) begin
            rdWord = {4'h0, avgFf[i]};
          end
        end
      end
    endcase
  end
endmodule

// *** verification/mrt_fe_model.sv ***
// Front-end converter model answering the telemetry sequencer
`timescale 1ns/1ps
module mrt_fe_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic adcStart,
  input wire logic [2:0] adcChan,
  input wire logic [11:0] tempCode,
  output logic adcDone,
  output logic [11:0] adcData
);
  logic [1:0] busyFf;
  logic [2:0] chanFf;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busyFf <= 2'h0;
      chanFf <= 3'h0;
      adcDone <= 1'b0;
      adcData <= 12'h000;
    end else begin
      adcDone <= busyFf == 2'h1;
      busyFf <= adcStart ? 2'h3 : (busyFf != 2'h0 ? busyFf - 2'h1 : 2'h0);
      if (adcStart) chanFf <= adcChan;
      // Outside a result the bus toggles, so stale data never looks valid
      if (busyFf != 2'h1) adcData <= ~adcData;
      else if (chanFf == 3'h4) adcData <= 12'h010;
      else if (chanFf == 3'h5) adcData <= 12'h010 + tempCode;
      else adcData <= 12'h100;
    end
  end
endmodule

// *** verification/mrt_monitor_props.sv ***
// Port-level checker for the monitor block
`timescale 1ns/1ps
module mrt_monitor_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic enablePin,
  input wire logic vddPorOk,
  input wire logic vrefPorOk,
  input wire logic sdaPinOut,
  input wire logic sdaPinOe,
  input wire logic alertLineOut,
  input wire logic alertLineOe,
  input wire logic adcStart,
  input wire logic [2:0] adcChan,
  input wire logic diodeHighCurrent,
  input wire logic currentRangeHigh,
  input wire logic lowPower,
  input wire logic otFault
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_chan_valid: assert property (
    adcStart |-> adcChan inside {[3'h1:3'h5]})
    else $error("conversion started on an unused channel");
  a_start_pulse: assert property (adcStart |=> !adcStart)
    else $error("conversion start longer than one cycle");
  a_diode_pulse: assert property (
    adcStart && adcChan == 3'h5 |=> diodeHighCurrent)
    else $error("no high excitation on high-pulse channel");
  a_diode_low: assert property (
    adcChan != 3'h5 && $past(adcChan) != 3'h5 |-> !diodeHighCurrent)
    else $error("high excitation outside its conversion");
  a_enable_low: assert property (!enablePin [*3] |=> lowPower)
    else $error("enable low without low-power state");
  a_por_low: assert property (
    (!vddPorOk || !vrefPorOk) [*3] |=> lowPower)
    else $error("rail loss without reset");
  a_quiet_pins: assert property (
    lowPower [*4] |-> !sdaPinOe && !alertLineOe)
    else $error("bus or alert driven while disabled");
  a_reset_state: assert property (
    lowPower [*4] |-> !otFault && !currentRangeHigh)
    else $error("state survives functional reset");
  a_open_drain: assert property (!sdaPinOut && !alertLineOut)
    else $error("open-drain pin drives high");
endmodule
bind mrt_monitor mrt_monitor_props chk (.clock(clock), .rst(rst),
  .enablePin(enablePin), .vddPorOk(vddPorOk), .vrefPorOk(vrefPorOk),
  .sdaPinOut(sdaPinOut), .sdaPinOe(sdaPinOe),
  .alertLineOut(alertLineOut), .alertLineOe(alertLineOe),
  .adcStart(adcStart), .adcChan(adcChan),
  .diodeHighCurrent(diodeHighCurrent),
  .currentRangeHigh(currentRangeHigh), .lowPower(lowPower),
  .otFault(otFault));

// *** verification/mrt_monitor_bench.sv ***
// Self-checking bench driving the monitor over its management bus
`timescale 1ns/1ps
module mrt_monitor_bench;
  import mrt_pkg::*;
  localparam int RR = 200;
  logic clock = 0, rst = 1, enablePin = 1, vddPorOk = 1, vrefPorOk = 1;
  logic [1:0] s0 = 2'h1, s1 = 2'h2, s2 = 2'h0;
  logic sclD = 1, sdaD = 1, a;
  logic [11:0] tempCode = 12'h200;
  logic sdaPinOut, sdaPinOe, alertLineOut, alertLineOe, adcStart, adcDone;
  logic diodeHighCurrent, currentRangeHigh, lowPower, otFault;
  logic [2:0] adcChan;
  mrt_code_t adcData;
  int num_errors = 0, samples_checked = 0;
  logic [6:0] adr = 7'h47;
  logic [15:0] q;
  wire sda = sdaD & ~sdaPinOe;
  always #10 clock = ~clock;
  mrt_monitor #(.RR_CYC(RR)) dut (.clock(clock), .rst(rst),
    .enablePin(enablePin), .vddPorOk(vddPorOk), .vrefPorOk(vrefPorOk),
    .addrStrapBit0(s0), .addrStrapBit1(s1), .addrStrapBit2(s2),
    .sclPin(sclD), .sdaPinIn(sda), .sdaPinOut(sdaPinOut),
    .sdaPinOe(sdaPinOe), .alertLineOut(alertLineOut),
    .alertLineOe(alertLineOe), .adcStart(adcStart), .adcChan(adcChan),
    .adcDone(adcDone), .adcData(adcData),
    .diodeHighCurrent(diodeHighCurrent),
    .currentRangeHigh(currentRangeHigh), .lowPower(lowPower),
    .otFault(otFault));
  mrt_fe_model fe (.clock(clock), .rst(rst), .adcStart(adcStart),
    .adcChan(adcChan), .tempCode(tempCode), .adcDone(adcDone),
    .adcData(adcData));
  task results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task hp;
    repeat (4) @(posedge clock);
  endtask
  // Data moves one clock after the clock falls to keep start/stop clean
  task bt(input logic b, output logic r);
    @(posedge clock) sdaD <= b;
    repeat (3) @(posedge clock);
    sclD <= 1;
    repeat (3) @(posedge clock);
    @(negedge clock) r = sda;
    @(posedge clock) sclD <= 0;
  endtask
  task by(input logic [7:0] d, input logic m, output logic [7:0] r,
    output logic k);
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(m, k);
  endtask
  task st;
    @(posedge clock) sdaD <= 1;
    hp;
    sclD <= 1;
    hp;
    sdaD <= 0;
    hp;
    sclD <= 0;
    hp;
  endtask
  task sp;
    @(posedge clock) sdaD <= 0;
    hp;
    sclD <= 1;
    hp;
    sdaD <= 1;
    hp;
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d, input int n,
    output logic k);
    logic [7:0] r;
    logic j;
    st;
    by({adr, 1'b0}, 1'b1, r, k);
    by(c, 1'b1, r, j);
    by(d[7:0], 1'b1, r, j);
    if (n > 1) by(d[15:8], 1'b1, r, j);
    sp;
  endtask
  task rd(input logic [7:0] c, output logic [15:0] d);
    logic [7:0] r;
    logic k;
    st;
    by({adr, 1'b0}, 1'b1, r, k);
    by(c, 1'b1, r, k);
    st;
    by({adr, 1'b1}, 1'b1, r, k);
    by(8'hFF, 1'b0, d[7:0], k);
    by(8'hFF, 1'b1, d[15:8], k);
    sp;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    $display("[ERR] run limit exp end got hang");
    results;
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    repeat (10) @(posedge clock);
    rd(8'h51, q); ck("warn default", 16'h07D0, q);
    rd(8'h4F, q); ck("fault default", 16'h0960, q);
    repeat (2 * RR) @(posedge clock);
    ck("alert idle", 16'h0, alertLineOe);
    rd(8'h8D, q); ck("temperature", 16'h0200, q);
    rd(8'hD5, q); ck("peak power", 16'h0010, q);
    rd(8'hE4, q); ck("avg temp", 16'h0200, q);
    $display("test defaults done");
    wr(8'h51, 16'h0100, 2, a); ck("warn ack", 16'h0, a);
    rd(8'h51, q); ck("warn new", 16'h0100, q);
    repeat (2 * RR) @(posedge clock);
    ck("alert set", 16'h1, alertLineOe);
    wr(8'h4F, 16'h0200, 2, a);
    repeat (2 * RR) @(posedge clock);
    ck("fault equal", 16'h0, otFault);
    wr(8'h4F, 16'h01FF, 2, a);
    repeat (2 * RR) @(posedge clock);
    ck("fault set", 16'h1, otFault);
    rd(8'h7D, q); ck("status", 16'h00C0, q);
    wr(8'hD9, 16'h0004, 1, a); ck("range", 16'h1, currentRangeHigh);
    $display("test limits done");
    wr(8'hD9, 16'h0080, 1, a);
    repeat (10) @(posedge clock);
    ck("soft range", 16'h0, currentRangeHigh);
    ck("soft alert", 16'h0, alertLineOe);
    rd(8'h51, q); ck("soft warn", 16'h07D0, q);
    $display("test soft reset done");
    enablePin <= 0;
    s2 <= 2'h2;
    repeat (10) @(posedge clock);
    ck("low power", 16'h1, lowPower);
    wr(8'h51, 16'h0100, 2, a); ck("ignored", 16'h1, a);
    enablePin <= 1;
    repeat (10) @(posedge clock);
    adr = 7'h59;
    rd(8'h51, q); ck("new address", 16'h07D0, q);
    adr = 7'h47;
    wr(8'h51, 16'h0100, 2, a); ck("old address", 16'h1, a);
    $display("test enable done");
    adr = 7'h59;
    wr(8'h51, 16'h0100, 2, a); ck("warn ack", 16'h0, a);
    vrefPorOk <= 0;
    repeat (5) @(posedge clock);
    ck("rail reset", 16'h1, lowPower);
    vrefPorOk <= 1;
    repeat (10) @(posedge clock);
    rd(8'h51, q); ck("rail warn", 16'h07D0, q);
    $display("test power-on done");
    results;
  end
endmodule
